// ### logic/ddrpc_device.sv
// Memory end: command decode, bank state and data lanes, all on the link clock
`include "ddrpc_cfg.svh"
`default_nettype none
module ddrpc_device (
  input  wire logic resetn,
  ddrpc_link_if.dev link,
  output logic [3:0] bank_open,
  output logic       termination_on,
  output logic       strobe_comp_on,
  output logic       access_error,
  output logic       internal_clock_on
);
  logic                         cke_prev_r;
  logic [3:0]                   bank_open_r;
  logic [3:0]                   bank_open_nxt;
  logic [`DDRPC_ROW_W-1:0]      open_row_r [0:3];
  logic                         comp_en_r;
  logic                         rtt_en_r;
  logic                         term_on_r;
  logic                         access_error_r;
  logic                         rd_pend_r;
  logic                         rd_act_r;
  logic [2:0]                   rd_dly_r;
  logic [1:0]                   rd_beat_r;
  logic [1:0]                   rd_bank_r;
  logic [`DDRPC_COL_W-1:0]      rd_col_r;
  logic                         rd_ap_r;
  logic                         wr_pend_r;
  logic                         wr_act_r;
  logic [2:0]                   wr_dly_r;
  logic [1:0]                   wr_beat_r;
  logic [1:0]                   wr_bank_r;
  logic [`DDRPC_COL_W-1:0]      wr_col_r;
  logic                         wr_ap_r;
  logic [15:0]                  dq_o_r;
  logic                         dq_oe_r;
  logic [1:0]                   strobe_o_r;
  logic                         strobe_oe_r;
  logic                         comp_oe_r;
  logic [15:0]                  mem [0:(1<<`DDRPC_MEM_AW)-1];
  // Storage is folded: two row bits and six column bits per bank are kept
  function automatic logic [`DDRPC_MEM_AW-1:0] mem_index(
    input logic [1:0]              bank,
    input logic [`DDRPC_ROW_W-1:0] row,
    input logic [`DDRPC_COL_W-1:0] col,
    input logic [1:0]              beat
  );
    logic [1:0] low;
    low = col[1:0] + beat;
    return {bank, row[1:0], col[5:2], low};
  endfunction : mem_index
  wire logic [3:0]              cmd_code;
  wire logic                    run;
  wire logic                    cmd_ok;
  wire logic                    is_act;
  wire logic                    is_pre;
  wire logic                    is_rd;
  wire logic                    is_wr;
  wire logic                    is_emr1;
  wire logic                    bank_hit;
  wire logic                    act_ok;
  wire logic                    rd_ok;
  wire logic                    wr_ok;
  wire logic                    rd_go;
  wire logic                    rd_out;
  wire logic [1:0]              rd_beat;
  wire logic                    rd_last;
  wire logic                    wr_go;
  wire logic                    wr_in;
  wire logic [1:0]              wr_beat;
  wire logic                    wr_last;
  wire logic [`DDRPC_MEM_AW-1:0] rd_idx;
  wire logic [`DDRPC_MEM_AW-1:0] wr_idx;
  wire logic [1:0]              lane_we;
  // Chip select is the top bit of the code, so a deselect never matches below
  assign cmd_code = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  // The internal clock runs only in the cycle after clock enable was seen high
  assign run      = cke_prev_r;
  assign cmd_ok   = run & link.cke & ~link.cs_n;
  assign is_act   = cmd_ok & (cmd_code == `DDRPC_CMD_ACT);
  assign is_pre   = cmd_ok & (cmd_code == `DDRPC_CMD_PRE);
  assign is_rd    = cmd_ok & (cmd_code == `DDRPC_CMD_RD);
  assign is_wr    = cmd_ok & (cmd_code == `DDRPC_CMD_WR);
  // No-op and every unlisted code fall through with no bank change
  assign is_emr1  = cmd_ok & (cmd_code == `DDRPC_CMD_EMRS) &
                    (link.bank_select == `DDRPC_EMR1_BANK);
  assign bank_hit = bank_open_r[link.bank_select];
  assign act_ok   = is_act & ~bank_hit;
  assign rd_ok    = is_rd & bank_hit;
  assign wr_ok    = is_wr & bank_hit;
  assign rd_go    = run & rd_pend_r & (rd_dly_r == 3'h0);
  assign rd_out   = rd_go | (run & rd_act_r);
  assign rd_beat  = rd_act_r ? rd_beat_r : 2'h0;
  assign rd_last  = rd_out & (rd_beat == 2'h3);
  assign wr_go    = run & wr_pend_r & (wr_dly_r == 3'h0);
  assign wr_in    = wr_go | (run & wr_act_r);
  assign wr_beat  = wr_act_r ? wr_beat_r : 2'h0;
  assign wr_last  = wr_in & (wr_beat == 2'h3);
  assign rd_idx   = mem_index(rd_bank_r, open_row_r[rd_bank_r], rd_col_r, rd_beat);
  assign wr_idx   = mem_index(wr_bank_r, open_row_r[wr_bank_r], wr_col_r, wr_beat);
  assign lane_we  = {~link.high_byte_write_mask, ~link.low_byte_write_mask} &
                    {2{wr_in}};
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      cke_prev_r <= 1'h0;
    end else begin
      cke_prev_r <= link.cke;
    end
  end
  always_comb begin
    bank_open_nxt = bank_open_r;
    if (rd_last && rd_ap_r) begin
      bank_open_nxt[rd_bank_r] = 1'h0;
    end
    if (wr_last && wr_ap_r) begin
      bank_open_nxt[wr_bank_r] = 1'h0;
    end
    if (act_ok) begin
      bank_open_nxt[link.bank_select] = 1'h1;
    end
    if (is_pre) begin
      if (link.addr[`DDRPC_AP_BIT]) begin
        bank_open_nxt = 4'h0;
      end else begin
        bank_open_nxt[link.bank_select] = 1'h0;
      end
    end
  end
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      bank_open_r    <= 4'h0;
      access_error_r <= 1'h0;
      for (int i = 0; i < 4; i++) begin
        open_row_r[i] <= 13'h0000;
      end
    end else begin
      bank_open_r    <= bank_open_nxt;
      access_error_r <= (is_act & bank_hit) | ((is_rd | is_wr) & ~bank_hit);
      if (act_ok) begin
        open_row_r[link.bank_select] <= link.addr;
      end
    end
  end
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      comp_en_r <= `DDRPC_RST_COMP_EN;
      rtt_en_r  <= `DDRPC_RST_RTT_EN;
      term_on_r <= 1'h0;
    end else begin
      if (is_emr1) begin
        comp_en_r <= ~link.addr[`DDRPC_EMR_COMP_OFF_BIT];
        rtt_en_r  <= link.addr[`DDRPC_EMR_RTT_BIT_A] | link.addr[`DDRPC_EMR_RTT_BIT_B];
      end
      term_on_r <= link.termination_enable & rtt_en_r;
    end
  end
  // A new read cuts short a running one, as a later command wins the lanes
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      rd_pend_r <= 1'h0;
      rd_act_r  <= 1'h0;
      rd_dly_r  <= 3'h0;
      rd_beat_r <= 2'h0;
      rd_bank_r <= 2'h0;
      rd_col_r  <= 10'h000;
      rd_ap_r   <= 1'h0;
    end else if (rd_ok) begin
      rd_pend_r <= 1'h1;
      rd_act_r  <= 1'h0;
      rd_dly_r  <= 3'(`DDRPC_RD_LAT - 1);
      rd_bank_r <= link.bank_select;
      rd_col_r  <= link.addr[`DDRPC_COL_W-1:0];
      rd_ap_r   <= link.addr[`DDRPC_AP_BIT];
    end else if (run && rd_pend_r) begin
      if (rd_go) begin
        rd_pend_r <= 1'h0;
        rd_act_r  <= 1'h1;
        rd_beat_r <= 2'h1;
      end else begin
        rd_dly_r <= rd_dly_r - 3'h1;
      end
    end else if (run && rd_act_r) begin
      rd_beat_r <= rd_beat_r + 2'h1;
      rd_act_r  <= ~rd_last;
    end
  end
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      wr_pend_r <= 1'h0;
      wr_act_r  <= 1'h0;
      wr_dly_r  <= 3'h0;
      wr_beat_r <= 2'h0;
      wr_bank_r <= 2'h0;
      wr_col_r  <= 10'h000;
      wr_ap_r   <= 1'h0;
    end else if (wr_ok) begin
      wr_pend_r <= 1'h1;
      wr_act_r  <= 1'h0;
      wr_dly_r  <= 3'(`DDRPC_WR_LAT - 1);
      wr_bank_r <= link.bank_select;
      wr_col_r  <= link.addr[`DDRPC_COL_W-1:0];
      wr_ap_r   <= link.addr[`DDRPC_AP_BIT];
    end else if (run && wr_pend_r) begin
      if (wr_go) begin
        wr_pend_r <= 1'h0;
        wr_act_r  <= 1'h1;
        wr_beat_r <= 2'h1;
      end else begin
        wr_dly_r <= wr_dly_r - 3'h1;
      end
    end else if (run && wr_act_r) begin
      wr_beat_r <= wr_beat_r + 2'h1;
      wr_act_r  <= ~wr_last;
    end
  end
  // Write data is taken on the rising link clock, half a period after the host moved it
  always_ff @(posedge link.ck) begin
    if (lane_we[0]) begin
      mem[wr_idx][7:0] <= link.data_lines[7:0];
    end
    if (lane_we[1]) begin
      mem[wr_idx][15:8] <= link.data_lines[15:8];
    end
  end
  // Data and strobe leave on the same edge; with the clock frozen they hold
  always_ff @(posedge link.ck or negedge resetn) begin
    if (!resetn) begin
      dq_o_r      <= 16'h0000;
      dq_oe_r     <= 1'h0;
      strobe_o_r  <= 2'h0;
      strobe_oe_r <= 1'h0;
      comp_oe_r   <= 1'h0;
    end else if (run) begin
      if (rd_out) begin
        dq_o_r      <= mem[rd_idx];
        dq_oe_r     <= 1'h1;
        strobe_o_r  <= {2{~rd_beat[0]}};
        strobe_oe_r <= 1'h1;
        comp_oe_r   <= comp_en_r;
      end else begin
        dq_oe_r     <= 1'h0;
        strobe_oe_r <= 1'h0;
        comp_oe_r   <= 1'h0;
      end
    end
  end
  assign link.d_dq_o      = dq_o_r;
  assign link.d_dq_oe     = dq_oe_r;
  assign link.d_strobe_o  = strobe_o_r;
  assign link.d_strobe_oe = strobe_oe_r;
  assign link.d_comp_oe   = comp_oe_r;
  assign bank_open         = bank_open_r;
  assign termination_on    = term_on_r;
  assign strobe_comp_on    = comp_en_r;
  assign access_error      = access_error_r;
  assign internal_clock_on = cke_prev_r;
endmodule : ddrpc_device
`default_nettype wire

// ### common/ddrpc_cfg.svh
// Command codes, address field positions, reset values and burst timing of the link
`ifndef DDRPC_CFG_SVH
`define DDRPC_CFG_SVH
`define DDRPC_CMD_EMRS          4'h0
`define DDRPC_CMD_PRE           4'h2
`define DDRPC_CMD_ACT           4'h3
`define DDRPC_CMD_WR            4'h4
`define DDRPC_CMD_RD            4'h5
`define DDRPC_CMD_NOP           4'h7
// A deselect carries a precharge pattern behind chip select, so masking is observable
`define DDRPC_CMD_DESEL         4'ha
`define DDRPC_ROW_W             13
`define DDRPC_COL_W             10
`define DDRPC_AP_BIT            10
`define DDRPC_EMR1_BANK         2'h1
`define DDRPC_EMR_COMP_OFF_BIT  10
`define DDRPC_EMR_RTT_BIT_A     2
`define DDRPC_EMR_RTT_BIT_B     6
`define DDRPC_RST_COMP_EN       1'h1
`define DDRPC_RST_RTT_EN        1'h0
`define DDRPC_BURST             4
`define DDRPC_WR_LAT            1
`define DDRPC_RD_LAT            2
`define DDRPC_MEM_AW            10
`endif

// ### common/ddrpc_pkg.sv
// Types of the controller end: request codes and its state
`default_nettype none
package ddrpc_pkg;
  typedef enum logic [2:0] {
    DDRPC_REQ_NOP,
    DDRPC_REQ_DESEL,
    DDRPC_REQ_ACT,
    DDRPC_REQ_PRE,
    DDRPC_REQ_RD,
    DDRPC_REQ_WR,
    DDRPC_REQ_EMRS
  } ddrpc_req_t;

  typedef enum logic [1:0] {
    DDRPC_H_IDLE,
    DDRPC_H_WRITE,
    DDRPC_H_READ
  } ddrpc_hstate_t;
endpackage : ddrpc_pkg
`default_nettype wire

// ### common/ddrpc_link_if.sv
// Pin-level link between controller and memory, with shared-wire resolution
`default_nettype none
interface ddrpc_link_if;
  logic        ck;
  logic        cke;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [1:0]  bank_select;
  logic [12:0] addr;
  logic        low_byte_write_mask;
  logic        high_byte_write_mask;
  logic        termination_enable;
  logic [15:0] h_dq_o;
  logic        h_dq_oe;
  logic [1:0]  h_strobe_o;
  logic        h_strobe_oe;
  logic        h_comp_oe;
  logic [15:0] d_dq_o;
  logic        d_dq_oe;
  logic [1:0]  d_strobe_o;
  logic        d_strobe_oe;
  logic        d_comp_oe;
  logic [15:0] data_lines;
  logic        low_byte_strobe;
  logic        high_byte_strobe;
  logic        low_byte_strobe_comp;
  logic        high_byte_strobe_comp;

  // An undriven wire reads low here; termination is not modelled electrically
  assign data_lines = d_dq_oe ? d_dq_o : (h_dq_oe ? h_dq_o : 16'h0000);
  assign low_byte_strobe  = d_strobe_oe ? d_strobe_o[0] : (h_strobe_oe & h_strobe_o[0]);
  assign high_byte_strobe = d_strobe_oe ? d_strobe_o[1] : (h_strobe_oe & h_strobe_o[1]);
  assign low_byte_strobe_comp  = d_comp_oe ? ~d_strobe_o[0] : (h_comp_oe & ~h_strobe_o[0]);
  assign high_byte_strobe_comp = d_comp_oe ? ~d_strobe_o[1] : (h_comp_oe & ~h_strobe_o[1]);

  modport host (
    output ck, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    output low_byte_write_mask, high_byte_write_mask, termination_enable,
    output h_dq_o, h_dq_oe, h_strobe_o, h_strobe_oe, h_comp_oe,
    input  data_lines, low_byte_strobe, high_byte_strobe,
    input  low_byte_strobe_comp, high_byte_strobe_comp
  );

  modport dev (
    input  ck, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
    input  low_byte_write_mask, high_byte_write_mask, termination_enable,
    output d_dq_o, d_dq_oe, d_strobe_o, d_strobe_oe, d_comp_oe,
    input  data_lines, low_byte_strobe, high_byte_strobe,
    input  low_byte_strobe_comp, high_byte_strobe_comp
  );
endinterface : ddrpc_link_if
`default_nettype wire

// ### logic/ddrpc_host.sv
// Controller end: divides its clock to make the link clock and issues commands and bursts
`include "ddrpc_cfg.svh"
`default_nettype none
module ddrpc_host (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  ddrpc_link_if.host                link,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire ddrpc_pkg::ddrpc_req_t req_cmd,
  input  wire logic [1:0]           req_bank,
  input  wire logic [12:0]          req_addr,
  input  wire logic [63:0]          req_wdata,
  input  wire logic [7:0]           req_wmask,
  input  wire logic                 clk_en_req,
  input  wire logic                 term_req,
  output logic                      rd_valid,
  output logic [63:0]               rd_data
);
  localparam logic [3:0] WR_FIRST = 4'(`DDRPC_WR_LAT);
  localparam logic [3:0] WR_LAST  = 4'(`DDRPC_WR_LAT + `DDRPC_BURST - 1);
  localparam logic [3:0] RD_FIRST = 4'(`DDRPC_RD_LAT + 1);
  localparam logic [3:0] RD_LAST  = 4'(`DDRPC_RD_LAT + `DDRPC_BURST);

  ddrpc_pkg::ddrpc_hstate_t state_r;
  logic        ck_r;
  logic [3:0]  cnt_r;
  logic        cke_r;
  logic [3:0]  cmd_r;
  logic [1:0]  bank_r;
  logic [12:0] addr_r;
  logic [1:0]  mask_r;
  logic        term_r;
  logic [15:0] dq_o_r;
  logic        dq_oe_r;
  logic [1:0]  strobe_o_r;
  logic        strobe_oe_r;
  logic        comp_oe_r;
  logic        comp_en_r;
  logic [63:0] wdata_r;
  logic [7:0]  wmask_r;
  logic        req_ready_r;
  logic        rd_valid_r;
  logic [63:0] rd_data_r;
  logic [3:0]  req_code;

  wire logic       tick;
  wire logic       take;
  wire logic [3:0] n;
  wire logic       wr_on;
  wire logic       rd_on;
  wire logic [1:0] wr_k;
  wire logic [1:0] rd_k;

  // Link outputs change on the falling link clock so they sit still around the rising one
  assign tick  = ck_r;
  assign take  = req_valid & req_ready_r;
  assign n     = cnt_r + 4'h1;
  assign wr_on = (state_r == ddrpc_pkg::DDRPC_H_WRITE) && (n >= WR_FIRST) && (n <= WR_LAST);
  assign rd_on = (state_r == ddrpc_pkg::DDRPC_H_READ) && (n >= RD_FIRST) && (n <= RD_LAST);
  assign wr_k  = 2'(n - WR_FIRST);
  assign rd_k  = 2'(n - RD_FIRST);

  always_comb begin
    case (req_cmd)
      ddrpc_pkg::DDRPC_REQ_DESEL: req_code = `DDRPC_CMD_DESEL;
      ddrpc_pkg::DDRPC_REQ_ACT:   req_code = `DDRPC_CMD_ACT;
      ddrpc_pkg::DDRPC_REQ_PRE:   req_code = `DDRPC_CMD_PRE;
      ddrpc_pkg::DDRPC_REQ_RD:    req_code = `DDRPC_CMD_RD;
      ddrpc_pkg::DDRPC_REQ_WR:    req_code = `DDRPC_CMD_WR;
      ddrpc_pkg::DDRPC_REQ_EMRS:  req_code = `DDRPC_CMD_EMRS;
      default:                    req_code = `DDRPC_CMD_NOP;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ck_r        <= 1'h0;
      req_ready_r <= 1'h0;
      rd_valid_r  <= 1'h0;
    end else begin
      ck_r        <= ~ck_r;
      req_ready_r <= ~ck_r && (state_r == ddrpc_pkg::DDRPC_H_IDLE);
      rd_valid_r  <= tick && rd_on && (n == RD_LAST);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r     <= ddrpc_pkg::DDRPC_H_IDLE;
      cnt_r       <= 4'h0;
      cke_r       <= 1'h0;
      cmd_r       <= `DDRPC_CMD_DESEL;
      bank_r      <= 2'h0;
      addr_r      <= 13'h0000;
      mask_r      <= 2'h0;
      term_r      <= 1'h0;
      dq_o_r      <= 16'h0000;
      dq_oe_r     <= 1'h0;
      strobe_o_r  <= 2'h0;
      strobe_oe_r <= 1'h0;
      comp_oe_r   <= 1'h0;
      comp_en_r   <= `DDRPC_RST_COMP_EN;
      wdata_r     <= 64'h0;
      wmask_r     <= 8'h00;
      rd_data_r   <= 64'h0;
    end else if (tick) begin
      cke_r       <= clk_en_req;
      term_r      <= term_req;
      cmd_r       <= `DDRPC_CMD_NOP;
      dq_oe_r     <= 1'h0;
      strobe_oe_r <= 1'h0;
      comp_oe_r   <= 1'h0;
      mask_r      <= 2'h0;
      case (state_r)
        ddrpc_pkg::DDRPC_H_IDLE: begin
          if (take) begin
            cmd_r   <= req_code;
            bank_r  <= req_bank;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
            wmask_r <= req_wmask;
            cnt_r   <= 4'h0;
            if (req_cmd == ddrpc_pkg::DDRPC_REQ_WR) begin
              state_r <= ddrpc_pkg::DDRPC_H_WRITE;
            end else if (req_cmd == ddrpc_pkg::DDRPC_REQ_RD) begin
              state_r <= ddrpc_pkg::DDRPC_H_READ;
            end
            if (req_cmd == ddrpc_pkg::DDRPC_REQ_EMRS && req_bank == `DDRPC_EMR1_BANK) begin
              comp_en_r <= ~req_addr[`DDRPC_EMR_COMP_OFF_BIT];
            end
          end
        end
        ddrpc_pkg::DDRPC_H_WRITE: begin
          cnt_r <= n;
          if (wr_on) begin
            dq_o_r      <= wdata_r[{wr_k, 4'h0} +: 16];
            mask_r      <= wmask_r[{wr_k, 1'h0} +: 2];
            dq_oe_r     <= 1'h1;
            strobe_o_r  <= {2{~wr_k[0]}};
            strobe_oe_r <= 1'h1;
            comp_oe_r   <= comp_en_r;
          end
          if (n == WR_LAST) begin
            state_r <= ddrpc_pkg::DDRPC_H_IDLE;
          end
        end
        ddrpc_pkg::DDRPC_H_READ: begin
          cnt_r <= n;
          if (rd_on) begin
            rd_data_r[{rd_k, 4'h0} +: 16] <= link.data_lines;
          end
          if (n == RD_LAST) begin
            state_r <= ddrpc_pkg::DDRPC_H_IDLE;
          end
        end
        default: state_r <= ddrpc_pkg::DDRPC_H_IDLE;
      endcase
    end
  end

  assign link.ck                   = ck_r;
  assign link.cke                  = cke_r;
  assign link.cs_n                 = cmd_r[3];
  assign link.ras_n                = cmd_r[2];
  assign link.cas_n                = cmd_r[1];
  assign link.we_n                 = cmd_r[0];
  assign link.bank_select          = bank_r;
  assign link.addr                 = addr_r;
  assign link.low_byte_write_mask  = mask_r[0];
  assign link.high_byte_write_mask = mask_r[1];
  assign link.termination_enable   = term_r;
  assign link.h_dq_o               = dq_o_r;
  assign link.h_dq_oe              = dq_oe_r;
  assign link.h_strobe_o           = strobe_o_r;
  assign link.h_strobe_oe          = strobe_oe_r;
  assign link.h_comp_oe            = comp_oe_r;
  assign req_ready                 = req_ready_r;
  assign rd_valid                  = rd_valid_r;
  assign rd_data                   = rd_data_r;
endmodule : ddrpc_host
`default_nettype wire

// ### sim/ddrpc_link_assertions.sv
// Link-side checks of command decode, read bursts, strobes and clock-enable freeze
`include "ddrpc_cfg.svh"
`default_nettype none
module ddrpc_link_assertions (
  input wire logic        ck,
  input wire logic        resetn,
  input wire logic        cke,
  input wire logic        cs_n,
  input wire logic        ras_n,
  input wire logic        cas_n,
  input wire logic        we_n,
  input wire logic [1:0]  bank_select,
  input wire logic [12:0] addr,
  input wire logic        h_dq_oe,
  input wire logic [15:0] d_dq_o,
  input wire logic        d_dq_oe,
  input wire logic [1:0]  d_strobe_o,
  input wire logic        d_strobe_oe,
  input wire logic        d_comp_oe
);
  logic       cke_r;
  logic [3:0] open_r;
  logic       comp_r;
  wire [3:0] cmd      = {cs_n, ras_n, cas_n, we_n};
  wire       live     = cke & cke_r;
  wire       is_act   = live & (cmd == `DDRPC_CMD_ACT);
  wire       is_pre   = live & (cmd == `DDRPC_CMD_PRE);
  wire       is_rd    = live & (cmd == `DDRPC_CMD_RD);
  wire       is_wr    = live & (cmd == `DDRPC_CMD_WR);
  wire       is_emr1  = live & (cmd == `DDRPC_CMD_EMRS) & (bank_select == `DDRPC_EMR1_BANK);
  wire [3:0] bank_bit = 4'h1 << bank_select;
  wire       rd_ok    = is_rd & (|(open_r & bank_bit));
  // Auto-precharge clears at once; the host cannot reach that bank before the burst ends
  wire       close_1  = is_pre | ((is_rd | is_wr) & addr[`DDRPC_AP_BIT]);
  wire [3:0] open_nxt = (is_pre & addr[`DDRPC_AP_BIT]) ? 4'h0 :
                        is_act ? (open_r | bank_bit) : close_1 ? (open_r & ~bank_bit) : open_r;
  always_ff @(posedge ck or negedge resetn) begin
    if (!resetn) begin
      cke_r  <= 1'h0;
      open_r <= 4'h0;
      comp_r <= `DDRPC_RST_COMP_EN;
    end else begin
      cke_r  <= cke;
      open_r <= open_nxt;
      comp_r <= is_emr1 ? ~addr[`DDRPC_EMR_COMP_OFF_BIT] : comp_r;
    end
  end
  default clocking @(posedge ck); endclocking
  default disable iff (!resetn);
  property p_rd_lat;
    rd_ok |-> ##3 (d_dq_oe && d_strobe_oe) [*4] ##1 !d_dq_oe;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read burst late or wrong length");
  property p_strobe;
    $rose(d_strobe_oe) |-> d_strobe_o == 2'h3 ##1 d_strobe_o == 2'h0 ##1 d_strobe_o == 2'h3
      ##1 d_strobe_o == 2'h0;
  endproperty
  a_strobe: assert property (p_strobe) else $error("read strobe not edge aligned");
  property p_comp;
    d_strobe_oe |-> d_comp_oe == comp_r;
  endproperty
  a_comp: assert property (p_comp) else $error("complement strobe mode wrong");
  property p_rd_cause;
    $rose(d_dq_oe) |-> $past(rd_ok, 3);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("data driven without read");
  property p_wr_quiet;
    is_wr |-> ##1 !d_dq_oe [*5];
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drove during write");
  property p_freeze;
    !cke [*2] |=> $stable({d_dq_oe, d_dq_o, d_strobe_oe, d_strobe_o});
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_oe_excl;
    d_dq_oe |-> !h_dq_oe;
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both ends drive data");
  property p_closed;
    is_rd && !rd_ok |-> ##1 !d_dq_oe [*4];
  endproperty
  a_closed: assert property (p_closed) else $error("read of closed bank drove data");
endmodule : ddrpc_link_assertions
`default_nettype wire

// ### sim/testbench.sv
// Both link ends back to back, driven through the controller request port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  clock, resetn, req_valid, req_ready, clk_en_req, term_req, rd_valid;
  logic                  termination_on, strobe_comp_on, access_error, internal_clock_on;
  logic                  err_seen;
  ddrpc_pkg::ddrpc_req_t req_cmd;
  logic [1:0]            req_bank;
  logic [12:0]           req_addr;
  logic [63:0]           req_wdata, rd_data, got;
  logic [7:0]            req_wmask;
  logic [3:0]            bank_open;
  int                    n_mismatch, checked;
  ddrpc_link_if link_i ();
  ddrpc_host ddrpc_host_i (.clock(clock), .resetn(resetn), .link(link_i), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_wmask(req_wmask), .clk_en_req(clk_en_req),
    .term_req(term_req), .rd_valid(rd_valid), .rd_data(rd_data));
  ddrpc_device ddrpc_device_i (.resetn(resetn), .link(link_i), .bank_open(bank_open),
    .termination_on(termination_on), .strobe_comp_on(strobe_comp_on),
    .access_error(access_error), .internal_clock_on(internal_clock_on));
  ddrpc_link_assertions chk_i (.ck(link_i.ck), .resetn(resetn), .cke(link_i.cke),
    .cs_n(link_i.cs_n), .ras_n(link_i.ras_n), .cas_n(link_i.cas_n), .we_n(link_i.we_n),
    .bank_select(link_i.bank_select), .addr(link_i.addr), .h_dq_oe(link_i.h_dq_oe),
    .d_dq_o(link_i.d_dq_o), .d_dq_oe(link_i.d_dq_oe), .d_strobe_o(link_i.d_strobe_o),
    .d_strobe_oe(link_i.d_strobe_oe), .d_comp_oe(link_i.d_comp_oe));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  // Error pulses last one link period, so they are caught here for later checking
  always @(posedge link_i.ck) if (access_error === 1'h1) err_seen = 1'h1;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  // Spacing of 16 cycles covers the longest burst, so requests never overlap
  task automatic req(input ddrpc_pkg::ddrpc_req_t c, input logic [1:0] b,
                     input logic [12:0] a, input logic [63:0] d = 64'h0,
                     input logic [7:0] m = 8'h0);
    int n = 0;
    @(posedge clock);
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= d;
    req_wmask <= m;
    req_valid <= 1'h1;
    @(negedge clock);
    while (req_ready !== 1'h1 && n < 100) begin
      n++;
      @(negedge clock);
    end
    if (n >= 100) n_mismatch++;
    @(posedge clock);
    req_valid <= 1'h0;
    repeat (16) begin
      @(negedge clock);
      if (rd_valid === 1'h1) got = rd_data;
    end
  endtask : req
  initial begin
    resetn = 1'h0;
    req_valid = 1'h0;
    req_cmd = ddrpc_pkg::DDRPC_REQ_NOP;
    {req_bank, req_addr, req_wdata, req_wmask} = '0;
    {clk_en_req, term_req, err_seen, n_mismatch, checked} = '0;
    clk_en_req = 1'h1;
    term_req = 1'h1;
    repeat (6) @(posedge clock);
    resetn <= 1'h1;
    repeat (8) @(posedge clock);
    req(ddrpc_pkg::DDRPC_REQ_EMRS, 2'h1, 13'h0000);
    check(termination_on, 1'h0);
    req(ddrpc_pkg::DDRPC_REQ_EMRS, 2'h1, 13'h0004);
    check(termination_on, 1'h1);
    @(posedge clock) term_req <= 1'h0;
    repeat (8) @(negedge clock);
    check(termination_on, 1'h0);
    req(ddrpc_pkg::DDRPC_REQ_ACT, 2'h2, 13'h1555);
    check(bank_open, 4'h4);
    req(ddrpc_pkg::DDRPC_REQ_DESEL, 2'h2, 13'h0400);
    req(ddrpc_pkg::DDRPC_REQ_NOP, 2'h1, 13'h0000);
    check(bank_open, 4'h4);
    req(ddrpc_pkg::DDRPC_REQ_WR, 2'h2, 13'h0000, 64'h1111_2222_3333_4444, 8'h00);
    req(ddrpc_pkg::DDRPC_REQ_WR, 2'h2, 13'h0000, 64'haaaa_bbbb_cccc_dddd, 8'h06);
    req(ddrpc_pkg::DDRPC_REQ_RD, 2'h2, 13'h0000);
    check(got, 64'haaaa_bbbb_cc33_44dd);
    err_seen = 1'h0;
    req(ddrpc_pkg::DDRPC_REQ_RD, 2'h0, 13'h0000);
    check(err_seen, 1'h1);
    req(ddrpc_pkg::DDRPC_REQ_RD, 2'h2, 13'h0400);
    check(bank_open, 4'h0);
    req(ddrpc_pkg::DDRPC_REQ_ACT, 2'h1, 13'h0000);
    req(ddrpc_pkg::DDRPC_REQ_ACT, 2'h3, 13'h0000);
    req(ddrpc_pkg::DDRPC_REQ_PRE, 2'h1, 13'h0000);
    check(bank_open, 4'h8);
    req(ddrpc_pkg::DDRPC_REQ_PRE, 2'h0, 13'h0400);
    check(bank_open, 4'h0);
    req(ddrpc_pkg::DDRPC_REQ_EMRS, 2'h1, 13'h0400);
    check(strobe_comp_on, 1'h0);
    req(ddrpc_pkg::DDRPC_REQ_ACT, 2'h0, 13'h0000);
    req(ddrpc_pkg::DDRPC_REQ_WR, 2'h0, 13'h0008, 64'h0123_4567_89ab_cdef, 8'h00);
    req(ddrpc_pkg::DDRPC_REQ_RD, 2'h0, 13'h0008);
    check(got, 64'h0123_4567_89ab_cdef);
    @(posedge clock) clk_en_req <= 1'h0;
    repeat (8) @(negedge clock);
    check(internal_clock_on, 1'h0);
    req(ddrpc_pkg::DDRPC_REQ_ACT, 2'h1, 13'h0000);
    check(bank_open, 4'h1);
    @(posedge clock) clk_en_req <= 1'h1;
    repeat (8) @(negedge clock);
    check(internal_clock_on, 1'h1);
    req(ddrpc_pkg::DDRPC_REQ_WR, 2'h0, 13'h0408, 64'h0, 8'hff);
    check(bank_open, 4'h0);
    conclude();
  end
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
